//--- shared/vdnc_regs.svh
// Register map, field positions and reset values of the denoise control bank
// Included by the package and by the register bank; definitions only
`ifndef VDNC_REGS_SVH
`define VDNC_REGS_SVH

// ==========================================================================
// Offsets
`define VDNC_OFS_CORE_CONTROL    12'h000
`define VDNC_OFS_EVENT_FLAGS     12'h004
`define VDNC_OFS_FAULT_FLAGS     12'h008
`define VDNC_OFS_INTERRUPT_MASK  12'h00C
`define VDNC_OFS_CORE_REVISION   12'h010
`define VDNC_OFS_FRAME_COUNTER   12'h014
`define VDNC_OFS_LINE_COUNTER    12'h018
`define VDNC_OFS_PIXEL_COUNTER   12'h01C
`define VDNC_OFS_FRAME_DIMS      12'h020
`define VDNC_OFS_CURVE_LOAD      12'h100
`define VDNC_OFS_CURVE_BANK      12'h104
`define VDNC_OFS_NOISE_EST       12'h108
`define VDNC_OFS_MOTION_EST      12'h10C

// ==========================================================================
// Field positions
`define VDNC_CTL_RUN             0
`define VDNC_CTL_COMMIT          1
`define VDNC_CTL_BYPASS          2
`define VDNC_CTL_SYNC_RST        30
`define VDNC_CTL_IMM_RST         31
`define VDNC_EVT_STARTED         0
`define VDNC_EVT_COMPLETE        1
`define VDNC_EVT_FAULT           2
`define VDNC_DIM_PIX_LSB         0
`define VDNC_DIM_LINE_LSB        16
`define VDNC_LOAD_DATA_LSB       0
`define VDNC_LOAD_ADDR_LSB       16

// ==========================================================================
// Widths and reset values
`define VDNC_DIM_W               13
`define VDNC_LOAD_DATA_W         8
`define VDNC_LOAD_ADDR_W         12
`define VDNC_BANK_W              4
`define VDNC_EVT_W               3
`define VDNC_FAULT_W             10
`define VDNC_CTL_RESET           32'h0000_0000
`define VDNC_MASK_RESET          3'h0

`endif

//--- shared/vdnc_pkg.sv
// Types shared by the denoise control bank
// Assumes vdnc_regs.svh on the include path
`default_nettype none
`include "vdnc_regs.svh"

package vdnc_pkg;
  // ==========================================================================
  // Frame tracking and bus response codes
  typedef enum logic [0:0] {
    VDNC_IDLE     = 1'b0,
    VDNC_IN_FRAME = 1'b1
  } vdnc_frame_t;

  typedef enum logic [1:0] {
    VDNC_RESP_OKAY   = 2'b00,
    VDNC_RESP_SLVERR = 2'b10
  } vdnc_resp_t;
endpackage : vdnc_pkg

`default_nettype wire

//--- rtl/vdnc_ctrl_regs.sv
// Control and status register bank of a temporal video denoise core
// Assumes an AXI4-Lite master on the core clock and stream event pulses from the datapath
//
// Functional notes
// RQ1: Clearing the run bit stops processing and blocks all stream events.
// RQ2: Run bit resets to zero and acts immediately, unsynchronised to frames.
// RQ3: Staged settings move to the active set at frame start when commit set.
// RQ4: Only frame dimensions and curve bank are double buffered.
// RQ5: Bypass bit switches noise reduction off while set.
// RQ6: Immediate reinit bit holds the core at defaults while set.
// RQ7: Frame-synced reset acts at frame end, or at once between frames.
// RQ8: Frame-synced reset bit clears itself once that reset is done.
// RQ9: Both reset bits default to zero; the reset pin always resets.
// RQ10: Event flags are sticky; writing one clears, writing zero keeps.
// RQ11: Frame-started flag sets on a valid start of frame.
// RQ12: Frame-complete flag sets when all programmed lines arrived.
// RQ13: Fault flag sets whenever any stream fault bit gets set.
// RQ14: Frame dimensions: pixels in bits 12..0, lines in bits 28..16.
// RQ15: Curve load register carries data 7..0 and address 27..16.
// RQ16: Curve bank select bits 3..0 choose the bank in use.
// RQ17: Noise and motion estimates are read only and reset to zero.
// RQ18: Frame, line and pixel counters are 32-bit, read only, reset zero.
// RQ19: Interrupt is OR of event flags 0..2 masked by interrupt mask; the code also ORs any set fault bit into the flag 2 term.
// RQ20: Fault bits are sticky, write-one-clear; interrupt holds until cleared.
// RQ21: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "vdnc_regs.svh"

module vdnc_ctrl_regs #(
  parameter logic [12:0] DEFAULT_PIXELS = 13'h0780,
  parameter logic [12:0] DEFAULT_LINES  = 13'h0438,
  parameter logic [3:0]  DEFAULT_BANK   = 4'h0,
  parameter logic [31:0] REVISION_ID    = 32'h0001_0000  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // AXI4-Lite write channels
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Stream events from the datapath
  input  wire logic        curr_sof,
  input  wire logic        line_end,
  input  wire logic        pixel_accept,
  input  wire logic [9:0]  fault_events,
  input  wire logic        estimate_valid,
  input  wire logic [31:0] noise_in,
  input  wire logic [31:0] motion_in,
  // Controls to the datapath
  output logic             core_run,
  output logic             filter_bypass,
  output logic             core_hold,
  output logic [12:0]      active_pixels,
  output logic [12:0]      active_lines,
  output logic [3:0]       active_bank,
  output logic             curve_wr_en,
  output logic [11:0]      curve_wr_addr,
  output logic [7:0]       curve_wr_data,
  // Interrupt
  output logic             irq
);

  // ==========================================================================
  // Elaboration checks
  if (DEFAULT_PIXELS < 13'h0020 || DEFAULT_LINES < 13'h0020) begin : g_bad_dims
    $error("Default frame dimensions below the minimum of 32");
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] vdnc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : vdnc_merge

  function automatic logic vdnc_mapped(input logic [11:0] a);
    return a == `VDNC_OFS_CORE_CONTROL || a == `VDNC_OFS_EVENT_FLAGS || a == `VDNC_OFS_FAULT_FLAGS
        || a == `VDNC_OFS_INTERRUPT_MASK || a == `VDNC_OFS_CORE_REVISION || a == `VDNC_OFS_FRAME_COUNTER
        || a == `VDNC_OFS_LINE_COUNTER || a == `VDNC_OFS_PIXEL_COUNTER || a == `VDNC_OFS_FRAME_DIMS
        || a == `VDNC_OFS_CURVE_LOAD || a == `VDNC_OFS_CURVE_BANK || a == `VDNC_OFS_NOISE_EST
        || a == `VDNC_OFS_MOTION_EST;
  endfunction : vdnc_mapped

  // ==========================================================================
  // State
  logic                run_bit;
  logic                commit_bit;
  logic                bypass_bit;
  logic                sync_rst_bit;
  logic                imm_rst_bit;
  logic [2:0]          event_flags;
  logic [9:0]          fault_flags;
  logic [2:0]          interrupt_mask;
  logic [31:0]         frame_counter;
  logic [31:0]         line_counter;
  logic [31:0]         pixel_counter;
  logic [12:0]         staged_pixels;
  logic [12:0]         staged_lines;
  logic [3:0]          staged_bank;
  logic [31:0]         noise_estimate;
  logic [31:0]         motion_estimate;
  logic [12:0]         lines_seen;
  vdnc_pkg::vdnc_frame_t frame_state;

  // ==========================================================================
  // Bus decode
  wire        wr_fire   = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire [11:0] wr_addr   = {s_axi_awaddr[11:2], 2'b00};
  wire [11:0] rd_addr   = {s_axi_araddr[11:2], 2'b00};
  wire        rd_fire   = s_axi_arvalid && !s_axi_rvalid;
  wire        wr_ctl    = wr_fire && wr_addr == `VDNC_OFS_CORE_CONTROL;
  wire        wr_evt    = wr_fire && wr_addr == `VDNC_OFS_EVENT_FLAGS;
  wire        wr_flt    = wr_fire && wr_addr == `VDNC_OFS_FAULT_FLAGS;
  wire        wr_msk    = wr_fire && wr_addr == `VDNC_OFS_INTERRUPT_MASK;
  wire        wr_dim    = wr_fire && wr_addr == `VDNC_OFS_FRAME_DIMS;
  wire        wr_load   = wr_fire && wr_addr == `VDNC_OFS_CURVE_LOAD;
  wire        wr_bank   = wr_fire && wr_addr == `VDNC_OFS_CURVE_BANK;
  wire [31:0] ctl_word  = {imm_rst_bit, sync_rst_bit, 27'h0, bypass_bit, commit_bit, run_bit};
  wire [31:0] dim_word  = {3'h0, staged_lines, 3'h0, staged_pixels};
  wire [31:0] ctl_new   = vdnc_merge(ctl_word, s_axi_wdata, s_axi_wstrb);
  wire [31:0] dim_new   = vdnc_merge(dim_word, s_axi_wdata, s_axi_wstrb);
  wire [31:0] bank_new  = vdnc_merge({28'h0, staged_bank}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] msk_new   = vdnc_merge({29'h0, interrupt_mask}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] clr_bits  = vdnc_merge(32'h0, s_axi_wdata, s_axi_wstrb);
  wire [31:0] load_word = vdnc_merge(32'h0, s_axi_wdata, s_axi_wstrb);

  // ==========================================================================
  // Frame tracking and resets
  wire       live        = run_bit && !imm_rst_bit;                                   // [RQ1] [RQ2]
  wire       sof_ok      = live && curr_sof;
  wire       eol_ok      = live && line_end && frame_state == vdnc_pkg::VDNC_IN_FRAME;
  wire [12:0] lines_next = lines_seen + 13'h0001;
  wire       frame_done  = eol_ok && lines_next == active_lines;                       // [RQ12]
  wire       sync_fire   = sync_rst_bit && (frame_state == vdnc_pkg::VDNC_IDLE || frame_done); // [RQ7]
  wire       clear_core  = imm_rst_bit || sync_fire;                                  // [RQ6]
  wire       commit_now  = sof_ok && commit_bit;                                      // [RQ3]
  wire       fault_new   = |fault_events && live;

  // ==========================================================================
  // Control register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      run_bit      <= 1'b0;                                                           // [RQ2] [RQ9]
      commit_bit   <= 1'b0;
      bypass_bit   <= 1'b0;
      sync_rst_bit <= 1'b0;
      imm_rst_bit  <= 1'b0;
    end else if (wr_ctl) begin
      run_bit      <= ctl_new[`VDNC_CTL_RUN];
      commit_bit   <= ctl_new[`VDNC_CTL_COMMIT];
      bypass_bit   <= ctl_new[`VDNC_CTL_BYPASS];                                      // [RQ5]
      sync_rst_bit <= ctl_new[`VDNC_CTL_SYNC_RST];
      imm_rst_bit  <= ctl_new[`VDNC_CTL_IMM_RST];
    end else if (sync_fire) begin
      sync_rst_bit <= 1'b0;                                                           // [RQ8]
    end
  end

  // ==========================================================================
  // Sticky flags, set wins over clear
  always_ff @(posedge clk) begin
    if (!rstn || clear_core) begin
      event_flags <= 3'h0;
      fault_flags <= 10'h000;
    end else begin
      event_flags <= (event_flags & ~(wr_evt ? clr_bits[2:0] : 3'h0))                 // [RQ10]
                   | {fault_new, frame_done, sof_ok};                                 // [RQ11] [RQ13]
      fault_flags <= (fault_flags & ~(wr_flt ? clr_bits[9:0] : 10'h000))              // [RQ20]
                   | (live ? fault_events : 10'h000);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      interrupt_mask <= `VDNC_MASK_RESET;
    end else if (wr_msk) begin
      interrupt_mask <= msk_new[2:0];
    end
  end

  // Fault term also follows the fault bits so the line stays up until they are cleared
  wire [2:0] irq_src = {event_flags[2] || |fault_flags, event_flags[1:0]};
  assign irq = |(irq_src & interrupt_mask);                                           // [RQ19] [RQ20]

  // ==========================================================================
  // Double-buffered settings
  always_ff @(posedge clk) begin
    if (!rstn || clear_core) begin
      staged_pixels <= DEFAULT_PIXELS;
      staged_lines  <= DEFAULT_LINES;
      staged_bank   <= DEFAULT_BANK;
      active_pixels <= DEFAULT_PIXELS;
      active_lines  <= DEFAULT_LINES;
      active_bank   <= DEFAULT_BANK;
    end else begin
      if (wr_dim) begin
        staged_pixels <= dim_new[`VDNC_DIM_PIX_LSB +: `VDNC_DIM_W];                   // [RQ14]
        staged_lines  <= dim_new[`VDNC_DIM_LINE_LSB +: `VDNC_DIM_W];
      end
      if (wr_bank) begin
        staged_bank <= bank_new[3:0];                                                 // [RQ16]
      end
      if (commit_now) begin
        active_pixels <= staged_pixels;                                               // [RQ4]
        active_lines  <= staged_lines;
        active_bank   <= staged_bank;
      end
    end
  end

  // ==========================================================================
  // Frame state and monitors
  always_ff @(posedge clk) begin
    if (!rstn || clear_core) begin
      frame_state   <= vdnc_pkg::VDNC_IDLE;
      lines_seen    <= 13'h0000;
      frame_counter <= 32'h0000_0000;                                                 // [RQ18]
      line_counter  <= 32'h0000_0000;
      pixel_counter <= 32'h0000_0000;
    end else begin
      if (sof_ok) begin
        frame_state <= vdnc_pkg::VDNC_IN_FRAME;
        lines_seen  <= 13'h0000;
      end else if (frame_done) begin
        frame_state <= vdnc_pkg::VDNC_IDLE;
      end else if (eol_ok) begin
        lines_seen <= lines_next;
      end
      if (frame_done) begin
        frame_counter <= frame_counter + 32'h0000_0001;
      end
      if (live && line_end) begin
        line_counter <= line_counter + 32'h0000_0001;
      end
      if (live && pixel_accept) begin
        pixel_counter <= pixel_counter + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || clear_core) begin
      noise_estimate  <= 32'h0000_0000;                                               // [RQ17]
      motion_estimate <= 32'h0000_0000;
    end else if (live && estimate_valid) begin
      noise_estimate  <= noise_in;
      motion_estimate <= motion_in;
    end
  end

  // ==========================================================================
  // Curve table load port
  always_ff @(posedge clk) begin
    if (!rstn) begin
      curve_wr_en   <= 1'b0;
      curve_wr_addr <= 12'h000;
      curve_wr_data <= 8'h00;
    end else begin
      curve_wr_en <= wr_load;
      if (wr_load) begin
        curve_wr_addr <= load_word[`VDNC_LOAD_ADDR_LSB +: `VDNC_LOAD_ADDR_W];        // [RQ15]
        curve_wr_data <= load_word[`VDNC_LOAD_DATA_LSB +: `VDNC_LOAD_DATA_W];
      end
    end
  end

  assign core_run      = live;                                                        // [RQ1]
  assign filter_bypass = bypass_bit;                                                  // [RQ5]
  assign core_hold     = clear_core;                                                  // [RQ6] [RQ7]

  // ==========================================================================
  // Bus responses
  logic [31:0] rd_mux;
  always_comb begin
    case (rd_addr)
      `VDNC_OFS_CORE_CONTROL:   rd_mux = ctl_word;                                    // [RQ21]
      `VDNC_OFS_EVENT_FLAGS:    rd_mux = {29'h0, event_flags};
      `VDNC_OFS_FAULT_FLAGS:    rd_mux = {22'h0, fault_flags};
      `VDNC_OFS_INTERRUPT_MASK: rd_mux = {29'h0, interrupt_mask};
      `VDNC_OFS_CORE_REVISION:  rd_mux = REVISION_ID;
      `VDNC_OFS_FRAME_COUNTER:  rd_mux = frame_counter;
      `VDNC_OFS_LINE_COUNTER:   rd_mux = line_counter;
      `VDNC_OFS_PIXEL_COUNTER:  rd_mux = pixel_counter;
      `VDNC_OFS_FRAME_DIMS:     rd_mux = dim_word;
      `VDNC_OFS_CURVE_BANK:     rd_mux = {28'h0, staged_bank};
      `VDNC_OFS_NOISE_EST:      rd_mux = noise_estimate;
      `VDNC_OFS_MOTION_EST:     rd_mux = motion_estimate;
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = rd_fire;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= vdnc_pkg::VDNC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= vdnc_pkg::VDNC_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= vdnc_mapped(wr_addr) ? vdnc_pkg::VDNC_RESP_OKAY : vdnc_pkg::VDNC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= vdnc_mapped(rd_addr) ? vdnc_pkg::VDNC_RESP_OKAY : vdnc_pkg::VDNC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_run_blocks_events: assert property (!run_bit ##1 1 |-> !$rose(event_flags[0]) || $past(wr_ctl)) // [RQ1]
    else $error("Frame started flag rose while stopped");
  a_run_reset_low: assert property ($rose(rstn) |-> !core_run)                          // [RQ2] [RQ9]
    else $error("Core running right after reset");
  a_commit_copies: assert property (commit_now && !clear_core |=> active_lines == $past(staged_lines)) // [RQ3]
    else $error("Commit did not copy staged lines");
  a_no_commit_hold: assert property (!commit_now && !clear_core |=> $stable(active_bank)) // [RQ4]
    else $error("Active bank changed without commit");
  a_bypass_follow: assert property (wr_ctl |=> filter_bypass ==                         // [RQ5]
                                    $past(s_axi_wstrb[0] ? s_axi_wdata[2] : bypass_bit))
    else $error("Bypass did not follow write");
  a_imm_holds: assert property (imm_rst_bit |=> frame_counter == 32'h0 && event_flags == 3'h0) // [RQ6]
    else $error("Immediate reinit did not hold state");
  a_sync_clears: assert property (sync_fire && !wr_ctl |=> !sync_rst_bit && lines_seen == 13'h0) // [RQ7] [RQ8]
    else $error("Frame-synced reset did not complete");
  a_flag_sticky: assert property (event_flags[1] && !wr_evt && !clear_core |=> event_flags[1]) // [RQ10]
    else $error("Complete flag dropped without clear");
  a_started_sets: assert property (sof_ok && !clear_core |=> event_flags[0])          // [RQ11]
    else $error("Start of frame not flagged");
  a_fault_sets: assert property (fault_new && !clear_core |=> event_flags[2] && |fault_flags) // [RQ13] [RQ20]
    else $error("Fault not flagged");
  a_irq_mask: assert property (interrupt_mask == 3'h0 |-> !irq)                        // [RQ19]
    else $error("Interrupt raised while masked");
  a_load_fields: assert property (wr_load && s_axi_wstrb == 4'hF |=> curve_wr_en       // [RQ15]
                                  && curve_wr_addr == $past(s_axi_wdata[27:16]))
    else $error("Curve load fields wrong");

  c_frame_done:  cover property (frame_done);
  c_commit:      cover property (commit_now);
  c_sync_in_frm: cover property (sync_rst_bit && frame_state == vdnc_pkg::VDNC_IN_FRAME ##[1:200] sync_fire);
  c_irq:         cover property ($rose(irq));

endmodule : vdnc_ctrl_regs

`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the denoise control register bank
// Assumes the design's header on the include path; the bench acts as bus master and datapath
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_wvalid = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic [3:0]  evs = 4'h0;
  logic [9:0]  fault_events = 10'h000;
  logic [31:0] noise_in = 32'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_run;
  logic        filter_bypass, core_hold, curve_wr_en, irq, pulse_q;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rresp_q, bresp_q;
  logic [31:0] s_axi_rdata, rdata_q;
  logic [12:0] active_pixels, active_lines;
  logic [3:0]  active_bank;
  logic [11:0] curve_wr_addr, addr_q;
  logic [7:0]  curve_wr_data, data_q;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;

  vdnc_ctrl_regs dut_u (.clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
    .curr_sof(evs[3]), .line_end(evs[2]), .pixel_accept(evs[1]), .fault_events(fault_events),
    .estimate_valid(evs[0]), .noise_in(noise_in), .motion_in(~noise_in), .core_run(core_run),
    .filter_bypass(filter_bypass), .core_hold(core_hold), .active_pixels(active_pixels),
    .active_lines(active_lines), .active_bank(active_bank), .curve_wr_en(curve_wr_en),
    .curve_wr_addr(curve_wr_addr), .curve_wr_data(curve_wr_data), .irq(irq));

  always #12.5 clk = ~clk;

  // Hang guard, well above the 120 or so cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Write response and curve pulse rise on the same edge, so the curve pulse is caught when bvalid is seen
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    bresp_q = s_axi_bresp;
    pulse_q = curve_wr_en;
    addr_q = curve_wr_addr;
    data_q = curve_wr_data;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rdata_q = s_axi_rdata;
    rresp_q = s_axi_rresp;
    chk(nm, rdata_q, exp);
  endtask : rd

  task automatic ev(input logic [3:0] v);
    evs <= v;
    @(posedge clk);
    evs <= 4'h0;
    @(posedge clk);
  endtask : ev

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rd(12'h000, 32'h0, "control");
    chk("core_run", {31'h0, core_run}, 32'h0);
    rd(12'h014, 32'h0, "frames");
    rd(12'h108, 32'h0, "noise");
    rd(12'h200, 32'h0, "unmapped");
    chk("unmapped resp", {30'h0, rresp_q}, 32'h2);
    rd(12'h010, 32'h0001_0000, "revision");
    rd(12'h100, 32'h0, "load reads zero");
    wr(12'h200, 32'hFFFF_FFFF);
    chk("unmapped wresp", {30'h0, bresp_q}, 32'h2);
    wr(12'h00C, 32'hFFFF_FFFF);
    rd(12'h00C, 32'h7, "mask");
  endtask : t_reset

  task automatic t_commit;
    wr(12'h000, 32'h5);
    chk("run", {31'h0, core_run}, 32'h1);
    chk("bypass", {31'h0, filter_bypass}, 32'h1);
    wr(12'h020, 32'h0003_0020);
    wr(12'h104, 32'h5);
    ev(4'h8);
    chk("no commit", {19'h0, active_pixels}, 32'h780);
    wr(12'h000, 32'h3);
    ev(4'h8);
    chk("pixels", {19'h0, active_pixels}, 32'h20);
    chk("lines", {19'h0, active_lines}, 32'h3);
    chk("bank", {28'h0, active_bank}, 32'h5);
    rd(12'h020, 32'h0003_0020, "dims read");
    rd(12'h104, 32'h5, "bank read");
    repeat (3) ev(4'h6);
    rd(12'h004, 32'h3, "flags");
    rd(12'h014, 32'h1, "frames");
    rd(12'h01C, 32'h3, "pixels count");
    rd(12'h018, 32'h3, "lines count");
    wr(12'h004, 32'h1);
    rd(12'h004, 32'h2, "flags w1c");
    wr(12'h000, 32'h0);
    ev(4'h8);
    rd(12'h004, 32'h2, "halted");
  endtask : t_commit

  task automatic t_fault;
    wr(12'h000, 32'h1);
    wr(12'h00C, 32'h4);
    fault_events <= 10'h008;
    @(posedge clk);
    fault_events <= 10'h000;
    rd(12'h008, 32'h8, "fault");
    rd(12'h004, 32'h6, "fault flag");
    chk("irq", {31'h0, irq}, 32'h1);
    wr(12'h004, 32'h4);
    chk("irq held", {31'h0, irq}, 32'h1);
    wr(12'h008, 32'h8);
    chk("irq off", {31'h0, irq}, 32'h0);
    wr(12'h100, 32'h0ABC_005A);
    chk("curve pulse", {31'h0, pulse_q}, 32'h1);
    chk("curve addr", {20'h0, addr_q}, 32'hABC);
    chk("curve data", {24'h0, data_q}, 32'h5A);
  endtask : t_fault

  task automatic t_resets;
    noise_in <= 32'h0000_1234;
    ev(4'h1);
    rd(12'h108, 32'h1234, "noise");
    rd(12'h10C, 32'hFFFF_EDCB, "motion");
    wr(12'h000, 32'h8000_0001);
    chk("hold", {31'h0, core_hold}, 32'h1);
    chk("run held", {31'h0, core_run}, 32'h0);
    rd(12'h108, 32'h0, "noise cleared");
    wr(12'h000, 32'h4000_0001);
    rd(12'h000, 32'h1, "sync self clear");
    rd(12'h014, 32'h0, "frames cleared");
    wr(12'h000, 32'h3);
    wr(12'h020, 32'h0002_0020);
    ev(4'h8);
    chk("sync lines", {19'h0, active_lines}, 32'h2);
    wr(12'h000, 32'h4000_0001);
    rd(12'h000, 32'h4000_0001, "sync pending");
    repeat (2) ev(4'h4);
    rd(12'h000, 32'h1, "sync done");
    rd(12'h014, 32'h0, "sync frames");
    chk("sync dflt", {19'h0, active_lines}, 32'h438);
  endtask : t_resets

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_commit();
    t_fault();
    t_resets();
    test_done();
  end
endmodule : tb_top

`default_nettype wire
